// [core/gpcfg_pkg.sv]
`default_nettype none

package gpcfg_pkg;

  // ==========================================================================
  // Register map, byte addresses.
  // ==========================================================================
  localparam logic [3:0] GPCFG_OFS_DRIVE   = 4'h0;
  localparam logic [3:0] GPCFG_OFS_PULLUP  = 4'h4;
  localparam logic [3:0] GPCFG_OFS_SLEW    = 4'h8;
  localparam logic [3:0] GPCFG_OFS_DIR     = 4'hc;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [7:0] GPCFG_RST_DRIVE   = 8'h00;
  localparam logic [7:0] GPCFG_RST_PULLUP  = 8'h00;
  localparam logic [7:0] GPCFG_RST_SLEW    = 8'h00;
  localparam logic [7:0] GPCFG_RST_DIR     = 8'h00;

  // ==========================================================================
  // Fixed pin properties.
  // ==========================================================================
  localparam int         GPCFG_INPUT_ONLY_POS = 1;
  localparam logic [7:0] GPCFG_EAST_USABLE    = 8'hfd;

  typedef enum logic [1:0] {
    GPCFG_IDLE = 2'b01,
    GPCFG_ACK  = 2'b10
  } gpcfg_bus_state_type;

endpackage : gpcfg_pkg

`default_nettype wire

// [core/gpcfg_pin_cell.sv]
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Per-pin pad control derivation, registered.
// ============================================================================
module gpcfg_pin_cell (
  input  wire logic clk_sys,        // System clock.
  input  wire logic reset,          // Synchronous reset, active high.
  input  wire logic east_out,       // East port pin is an output.
  input  wire logic east_usable,    // East pin can drive at all.
  input  wire logic drive_bit,      // Drive strength bit.
  input  wire logic jport_out,      // J port pin is an output.
  input  wire logic pullup_bit,     // Pull-up enable bit.
  input  wire logic slew_bit,       // Slew enable bit.
  input  wire logic irq_pulldown,   // Pin interrupt asks for a pull-down.
  output logic      drive_high,     // High drive to pad.
  output logic      pullup_on,      // Pull-up to pad.
  output logic      pulldown_on,    // Pull-down to pad.
  output logic      slew_on         // Slew control to pad.
);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drive_high  <= 1'b0;
      pullup_on   <= 1'b0;
      pulldown_on <= 1'b0;
      slew_on     <= 1'b0;
    end else begin
      drive_high  <= east_usable & east_out & drive_bit;          // [R2] [R3] [R4]
      pullup_on   <= ~jport_out & pullup_bit & ~irq_pulldown;     // [R6] [R7]
      pulldown_on <= ~jport_out & irq_pulldown;                   // [R7] [R8]
      slew_on     <= jport_out & slew_bit;                        // [R10] [R12]
    end
  end

endmodule // gpcfg_pin_cell

`default_nettype wire

// [core/gpcfg_top.sv]
`timescale 1ns/1ns
`default_nettype none

// Operation
// R1: Eight independent east port drive bits.
// R2: Drive bit zero low, one high.
// R3: Drive bit ignored on input pins.
// R4: Drive bit one has no effect.
// R5: Eight independent J port pull-up bits.
// R6: Pull bit one enables pull-up, zero disables.
// R7: Output J pins force pulls off.
// R8: Pull-down only with pin interrupt configured.
// R9: Eight independent J port slew bits.
// R10: Slew bit ignored on input pins.
// R11: Software sets slew explicitly after reset.
// R12: Slew bit one on, zero off.
// R13: Registers read back last written value.
module gpcfg_top (
  input  wire logic        clk_sys,         // System clock, 20 MHz.
  input  wire logic        reset,           // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,        // Wishbone cycle.
  input  wire logic        wb_stb_i,        // Wishbone strobe.
  input  wire logic        wb_we_i,         // Wishbone write enable.
  input  wire logic [3:0]  wb_adr_i,        // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,        // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,        // Wishbone write data.
  output logic      [31:0] wb_dat_o,        // Wishbone read data.
  output logic             wb_ack_o,        // Wishbone acknowledge.
  input  wire logic [7:0]  east_port_dir,   // East pin direction, 1 output.
  input  wire logic [7:0]  jport_irq_pull,  // J pin interrupt wants pull-down.
  output logic      [7:0]  east_port_pin_drive, // East pad high drive.
  output logic      [7:0]  jport_pin_pullup,    // J pad pull-up.
  output logic      [7:0]  jport_pin_pulldown,  // J pad pull-down.
  output logic      [7:0]  jport_pin_slew       // J pad slew control.
);
  import gpcfg_pkg::*;

  // ==========================================================================
  // Pin input synchronisers.
  // ==========================================================================
  logic [7:0] east_dir_meta;
  logic [7:0] east_dir_sync;
  logic [7:0] irq_meta;
  logic [7:0] irq_sync;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      east_dir_meta <= 8'h00;
      east_dir_sync <= 8'h00;
      irq_meta      <= 8'h00;
      irq_sync      <= 8'h00;
    end else begin
      east_dir_meta <= east_port_dir;
      east_dir_sync <= east_dir_meta;
      irq_meta      <= jport_irq_pull;
      irq_sync      <= irq_meta;
    end
  end

  // ==========================================================================
  // Wishbone slave, one wait state, ack for one cycle.
  // ==========================================================================
  gpcfg_bus_state_type bus_state_reg;
  logic                bus_req;
  logic                wr_fire;
  logic [7:0]          east_port_drive_bits;
  logic [7:0]          jport_pullup_bits;
  logic [7:0]          jport_slew_bits;
  logic [7:0]          jport_dir_reg;

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_fire = (bus_state_reg == GPCFG_IDLE) & bus_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_state_reg <= GPCFG_IDLE;
      wb_ack_o      <= 1'b0;
    end else begin
      unique case (bus_state_reg)
        GPCFG_IDLE: begin
          if (bus_req) begin
            bus_state_reg <= GPCFG_ACK;
            wb_ack_o      <= 1'b1;
          end
        end
        GPCFG_ACK: begin
          bus_state_reg <= GPCFG_IDLE;
          wb_ack_o      <= 1'b0;
        end
        default: begin
          bus_state_reg <= GPCFG_IDLE;
          wb_ack_o      <= 1'b0;
        end
      endcase
    end
  end

  // Configuration registers; a write lands on the edge that takes the request.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      east_port_drive_bits <= GPCFG_RST_DRIVE;
    end else if (wr_fire && wb_adr_i == GPCFG_OFS_DRIVE) begin
      east_port_drive_bits <= wb_dat_i[7:0];                        // [R1] [R13]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      jport_pullup_bits <= GPCFG_RST_PULLUP;
    end else if (wr_fire && wb_adr_i == GPCFG_OFS_PULLUP) begin
      jport_pullup_bits <= wb_dat_i[7:0];                           // [R5] [R13]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      jport_slew_bits <= GPCFG_RST_SLEW;
    end else if (wr_fire && wb_adr_i == GPCFG_OFS_SLEW) begin
      jport_slew_bits <= wb_dat_i[7:0];                             // [R9] [R13]
    end
  end

  // Own direction register for the J pins, a one marks an output.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      jport_dir_reg <= GPCFG_RST_DIR;
    end else if (wr_fire && wb_adr_i == GPCFG_OFS_DIR) begin
      jport_dir_reg <= wb_dat_i[7:0];
    end
  end

  // Read data; unmapped addresses read zero and still acknowledge.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if ((bus_state_reg == GPCFG_IDLE) & bus_req) begin
      unique case (wb_adr_i)
        GPCFG_OFS_DRIVE:  wb_dat_o <= {24'h000000, east_port_drive_bits}; // [R13]
        GPCFG_OFS_PULLUP: wb_dat_o <= {24'h000000, jport_pullup_bits};    // [R13]
        GPCFG_OFS_SLEW:   wb_dat_o <= {24'h000000, jport_slew_bits};      // [R13]
        GPCFG_OFS_DIR:    wb_dat_o <= {24'h000000, jport_dir_reg};
        default:          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Pad control, one cell per pin.
  // ==========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      gpcfg_pin_cell u_cell (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .east_out     (east_dir_sync[gi]),
        .east_usable  (GPCFG_EAST_USABLE[gi]),                    // [R4]
        .drive_bit    (east_port_drive_bits[gi]),                 // [R1]
        .jport_out    (jport_dir_reg[gi]),
        .pullup_bit   (jport_pullup_bits[gi]),                    // [R5]
        .slew_bit     (jport_slew_bits[gi]),                      // [R9]
        .irq_pulldown (irq_sync[gi]),                             // [R8]
        .drive_high   (east_port_pin_drive[gi]),
        .pullup_on    (jport_pin_pullup[gi]),
        .pulldown_on  (jport_pin_pulldown[gi]),
        .slew_on      (jport_pin_slew[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Checks.
  // ==========================================================================
  sequence s_bus_take;
    bus_state_reg == GPCFG_IDLE && bus_req;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence s_drive_write;
    wr_fire && wb_adr_i == GPCFG_OFS_DRIVE;
  endsequence

  sequence s_pullup_write;
    wr_fire && wb_adr_i == GPCFG_OFS_PULLUP;
  endsequence

  sequence s_slew_write;
    wr_fire && wb_adr_i == GPCFG_OFS_SLEW;
  endsequence

  sequence s_blind_write;
    bus_state_reg == GPCFG_IDLE && bus_req && wb_we_i && !wb_sel_i[0];
  endsequence

  sequence s_read_drive;
    bus_state_reg == GPCFG_IDLE && bus_req && !wb_we_i && wb_adr_i == GPCFG_OFS_DRIVE;
  endsequence

  sequence s_read_pullup;
    bus_state_reg == GPCFG_IDLE && bus_req && !wb_we_i && wb_adr_i == GPCFG_OFS_PULLUP;
  endsequence

  sequence s_read_slew;
    bus_state_reg == GPCFG_IDLE && bus_req && !wb_we_i && wb_adr_i == GPCFG_OFS_SLEW;
  endsequence

  a_drive_input_only: assert property (                          // [R4]
    @(posedge clk_sys) disable iff (reset)
    east_port_pin_drive[GPCFG_INPUT_ONLY_POS] == 1'b0)
    else $error("input-only east pin driven high");

  a_drive_follows: assert property (                             // [R1]
    @(posedge clk_sys) disable iff (reset)
    s_drive_write ##1 (east_dir_sync == 8'hff && $stable(east_dir_sync))
      |=> east_port_pin_drive == (east_port_drive_bits & GPCFG_EAST_USABLE))
    else $error("east drive does not follow register");

  a_drive_level: assert property (                               // [R2]
    @(posedge clk_sys) disable iff (reset)
    east_port_pin_drive[0] |-> $past(east_port_drive_bits[0]))
    else $error("east drive high without bit set");

  a_drive_low_off: assert property (                             // [R2]
    @(posedge clk_sys) disable iff (reset)
    (east_port_pin_drive & ~$past(east_port_drive_bits)) == 8'h00)
    else $error("east drive high with bit clear");

  a_drive_input: assert property (                               // [R3]
    @(posedge clk_sys) disable iff (reset)
    !$past(east_dir_sync[3]) |-> !east_port_pin_drive[3])
    else $error("east input pin has high drive");

  a_drive_inputs_all: assert property (                          // [R3]
    @(posedge clk_sys) disable iff (reset)
    (east_port_pin_drive & ~$past(east_dir_sync)) == 8'h00)
    else $error("east input pins have high drive");

  a_drive_lands: assert property (                               // [R1] [R13]
    @(posedge clk_sys) disable iff (reset)
    s_drive_write |=> east_port_drive_bits == $past(wb_dat_i[7:0]))
    else $error("drive write not stored");

  a_pullup_lands: assert property (                              // [R5] [R13]
    @(posedge clk_sys) disable iff (reset)
    s_pullup_write |=> jport_pullup_bits == $past(wb_dat_i[7:0]))
    else $error("pull-up write not stored");

  a_slew_lands: assert property (                                // [R9] [R13]
    @(posedge clk_sys) disable iff (reset)
    s_slew_write |=> jport_slew_bits == $past(wb_dat_i[7:0]))
    else $error("slew write not stored");

  a_write_no_sel: assert property (                              // [R13]
    @(posedge clk_sys) disable iff (reset)
    s_blind_write |=> $stable(east_port_drive_bits) && $stable(jport_pullup_bits)
      && $stable(jport_slew_bits) && $stable(jport_dir_reg))
    else $error("write without byte select changed a register");

  a_pull_output_off: assert property (                           // [R7]
    @(posedge clk_sys) disable iff (reset)
    $past(jport_dir_reg) != 8'h00 |->
      ((jport_pin_pullup | jport_pin_pulldown) & $past(jport_dir_reg)) == 8'h00)
    else $error("pull active on output pin");

  a_pull_enable: assert property (                               // [R5] [R6]
    @(posedge clk_sys) disable iff (reset)
    (jport_dir_reg == 8'h00 && irq_sync == 8'h00) |=>
      jport_pin_pullup == $past(jport_pullup_bits))
    else $error("pull-up does not match register");

  a_pulldown_follows: assert property (                          // [R7] [R8]
    @(posedge clk_sys) disable iff (reset)
    jport_pin_pulldown == ($past(irq_sync) & ~$past(jport_dir_reg)))
    else $error("pull-down does not follow pin interrupt");

  a_pulldown_cause: assert property (                            // [R8]
    @(posedge clk_sys) disable iff (reset)
    jport_pin_pulldown != 8'h00 |-> (jport_pin_pulldown & ~$past(irq_sync)) == 8'h00)
    else $error("pull-down without pin interrupt");

  a_slew_output: assert property (                               // [R9] [R12]
    @(posedge clk_sys) disable iff (reset)
    $past(jport_dir_reg) != 8'h00 |->
      (jport_pin_slew & $past(jport_dir_reg)) == ($past(jport_slew_bits) & $past(jport_dir_reg)))
    else $error("slew does not match register");

  a_slew_off_input: assert property (                            // [R10]
    @(posedge clk_sys) disable iff (reset)
    (jport_pin_slew & ~$past(jport_dir_reg)) == 8'h00)
    else $error("slew on input pin");

  a_bus_ack: assert property (                                   // [R13]
    @(posedge clk_sys) disable iff (reset)
    s_bus_take |=> s_ack_pulse)
    else $error("ack not one cycle after request");

  a_ack_cause: assert property (                                 // [R13]
    @(posedge clk_sys) disable iff (reset)
    $rose(wb_ack_o) |-> $past(bus_req))
    else $error("ack without request");

  a_ack_single: assert property (                                // [R13]
    @(posedge clk_sys) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  a_read_drive: assert property (                                // [R13]
    @(posedge clk_sys) disable iff (reset)
    s_read_drive |=> wb_dat_o == {24'h000000, $past(east_port_drive_bits)})
    else $error("drive register read back wrong");

  a_read_pullup: assert property (                               // [R13]
    @(posedge clk_sys) disable iff (reset)
    s_read_pullup |=> wb_dat_o == {24'h000000, $past(jport_pullup_bits)})
    else $error("pull-up register read back wrong");

  a_read_slew: assert property (                                 // [R13]
    @(posedge clk_sys) disable iff (reset)
    s_read_slew |=> wb_dat_o == {24'h000000, $past(jport_slew_bits)})
    else $error("slew register read back wrong");

  a_read_upper: assert property (                                // [R13]
    @(posedge clk_sys) disable iff (reset)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  a_data_holds: assert property (                                // [R13]
    @(posedge clk_sys) disable iff (reset)
    !(bus_state_reg == GPCFG_IDLE && bus_req) |=> $stable(wb_dat_o))
    else $error("read data changed without request");

  a_sync_path: assert property (                                 // [R3]
    @(posedge clk_sys) disable iff (reset)
    !$past(reset) && !$past(reset, 2) |-> east_dir_sync == $past(east_port_dir, 2))
    else $error("east direction not two flops behind pin");

  a_reset_quiet: assert property (                               // [R13]
    @(posedge clk_sys)
    $fell(reset) |-> !wb_ack_o && east_port_drive_bits == GPCFG_RST_DRIVE
      && jport_pullup_bits == GPCFG_RST_PULLUP && jport_slew_bits == GPCFG_RST_SLEW
      && jport_dir_reg == GPCFG_RST_DIR
      && (east_port_pin_drive | jport_pin_pullup | jport_pin_pulldown | jport_pin_slew) == 8'h00)
    else $error("state not at reset values after reset");

endmodule // gpcfg_top

`default_nettype wire

// [sim/gpcfg_pad_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Pad side: direction and pin-interrupt pull requests, launched from a flop.
// ============================================================================
module gpcfg_pad_model (
  input  wire logic       clk_sys,        // System clock.
  input  wire logic [7:0] dir_req,        // Requested east pin directions.
  input  wire logic [7:0] irq_req,        // Requested J pin pull-down asks.
  output logic      [7:0] east_port_dir,  // East pin direction to block.
  output logic      [7:0] jport_irq_pull  // J pin pull-down ask to block.
);
  always_ff @(posedge clk_sys) begin
    east_port_dir  <= dir_req;
    jport_irq_pull <= irq_req;
  end
endmodule // gpcfg_pad_model

`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import gpcfg_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic [7:0]  dir_req = 8'h00;
  logic [7:0]  irq_req = 8'h00;
  logic [7:0]  e_dir, j_irq, drv, pu, pd, sl;
  int          miscompares = 0;
  int          num_checks = 0;

  always #25 clk_sys = ~clk_sys;

  gpcfg_top dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .east_port_dir(e_dir), .jport_irq_pull(j_irq),
    .east_port_pin_drive(drv), .jport_pin_pullup(pu), .jport_pin_pulldown(pd),
    .jport_pin_slew(sl));

  gpcfg_pad_model pads (.clk_sys(clk_sys), .dir_req(dir_req), .irq_req(irq_req),
    .east_port_dir(e_dir), .jport_irq_pull(j_irq));

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; the request stands until ack is seen at a rising edge.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    @(posedge clk_sys);
    while (ack !== 1'b1) @(posedge clk_sys);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hf);
    check($sformatf("read %h", a), exp, q);
  endtask

  // Pad outputs lag their causes by at most four edges.
  task automatic pad_chk(input logic [7:0] e, input logic [7:0] u, input logic [7:0] n,
                         input logic [7:0] r);
    repeat (5) @(posedge clk_sys);
    check("east drive", {24'h0, e}, {24'h0, drv});
    check("j pullup", {24'h0, u}, {24'h0, pu});
    check("j pulldown", {24'h0, n}, {24'h0, pd});
    check("j slew", {24'h0, r}, {24'h0, sl});
  endtask

  initial begin
    #(50 * 3000);
    miscompares++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    dir_req <= 8'hff;
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), 32'h0);
    end
    pad_chk(8'h00, 8'h00, 8'h00, 8'h00);
    $display("test reset done");
    xfer(1'b1, GPCFG_OFS_DRIVE, 32'h0000_00ff, 4'h1);
    rd(GPCFG_OFS_DRIVE, 32'h0000_00ff);
    pad_chk(8'hfd, 8'h00, 8'h00, 8'h00);
    dir_req <= 8'h0f;
    xfer(1'b1, GPCFG_OFS_DRIVE, 32'h0000_005a, 4'h1);
    pad_chk(8'h08, 8'h00, 8'h00, 8'h00);
    $display("test east drive done");
    xfer(1'b1, GPCFG_OFS_SLEW, 32'h0000_003c, 4'h1);
    xfer(1'b1, GPCFG_OFS_PULLUP, 32'h0000_00a5, 4'h1);
    xfer(1'b1, GPCFG_OFS_DIR, 32'h0000_000f, 4'h1);
    pad_chk(8'h08, 8'ha0, 8'h00, 8'h0c);
    rd(GPCFG_OFS_PULLUP, 32'h0000_00a5);
    rd(GPCFG_OFS_SLEW, 32'h0000_003c);
    rd(GPCFG_OFS_DIR, 32'h0000_000f);
    $display("test j port done");
    irq_req <= 8'h81;
    pad_chk(8'h08, 8'h20, 8'h80, 8'h0c);
    irq_req <= 8'h00;
    pad_chk(8'h08, 8'ha0, 8'h00, 8'h0c);
    $display("test pull-down done");
    xfer(1'b1, GPCFG_OFS_SLEW, 32'h0000_00ff, 4'he);
    rd(GPCFG_OFS_SLEW, 32'h0000_003c);
    xfer(1'b1, 4'h2, 32'h0000_00ff, 4'h1);
    rd(4'h2, 32'h0);
    xfer(1'b1, GPCFG_OFS_DRIVE, 32'hffff_ff00, 4'hf);
    rd(GPCFG_OFS_DRIVE, 32'h0);
    pad_chk(8'h00, 8'ha0, 8'h00, 8'h0c);
    $display("test bus corners done");
    conclude();
  end
endmodule // tb_top

`default_nettype wire
